/* File: design/eeprom_access.sv */
// Purpose: data EEPROM access control behind an AXI4-Lite register port
// Assumes: osc_clk is the calibrated oscillator, sampled as a pin
// Notes:   the programming engine resets on por_rst; sys_rst clears only its mode, and only when idle
//
// Overview of operation
// (R1) strobe with armed enable starts programming stored data at address
// (R2) program strobe ignored unless arm bit set beforehand
// (R3) software arms by writing arm one with strobe zero
// (R4) software sets strobe within four cycles of arming
// (R5) software waits for strobe and flash self-program bits clear
// (R6) no programming start while flash self-programming is active
// (R7) flash wait only needed when software programs flash
// (R8) late strobe after arm expiry performs no write
// (R9) software keeps interrupts off during whole write sequence
// (R10) strobe bit clears itself when programming time elapses
// (R11) program strobe stalls the processor two cycles
// (R12) programming timed in calibrated oscillator cycles, 26368 atomic
// (R13) read strobe loads addressed byte into data register at once
// (R14) read strobe stalls the processor four cycles
// (R15) while programming, reads refused and address writes ignored
// (R16) software polls strobe clear before reading
// (R17) reset during programming still completes the byte
// (R18) mode 00 atomic, 01 erase, 10 write only, 11 reserved
// (R19) arm bit clears itself four cycles after set
// (R20) ready interrupt level high while strobe clear and enabled
// (R21) mode bit writes ignored while strobe set
// (R22) read strobe always reads back zero
// (R23) address, data and mode captured at start and held stable
//
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
module eeprom_access #(
  parameter int DEPTH      = 1024,
  parameter int OSC_ATOMIC = eeprom_pkg::OSC_ATOMIC,
  parameter int OSC_SPLIT  = eeprom_pkg::OSC_SPLIT
) (
  // clock and resets
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        por_rst,
  // calibrated oscillator and flash status
  input  wire logic        osc_clk,
  input  wire logic        flash_self_program_enable,
  // axi4-lite write
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // core side
  output logic             cpu_stall,
  output logic             ready_irq
);
  localparam int AW = $clog2(DEPTH);

  eeprom_pkg::core_t c_q, c_d;
  eeprom_pkg::eng_t  e_q, e_d;
  logic [7:0]        mem [DEPTH];
  logic              busy, start_pg, rd_req, rd_go, mode_wr, osc_tick, done;
  logic [7:0]        mem_rd;
  logic [1:0]        mode_wdata;
  logic [31:0]       ctrl_rd, rd_val;

  assign busy     = (e_q.st == eeprom_pkg::ENG_BUSY);
  assign osc_tick = e_q.osc_s2 && !e_q.osc_s3;
  assign done     = busy && osc_tick && (e_q.cnt == 15'h0000);
  assign mem_rd   = mem[c_q.addr[AW-1:0]];
  assign ctrl_rd  = {26'h0, e_q.mode, c_q.rie, c_q.arm, busy, 1'b0};

  // handshakes; one write and one read outstanding at most
  assign awready   = !c_q.aw_have && !c_q.bvalid;
  assign wready    = !c_q.w_have && !c_q.bvalid;
  assign arready   = !c_q.rvalid;
  assign bvalid    = c_q.bvalid;
  assign bresp     = c_q.bresp;
  assign rvalid    = c_q.rvalid;
  assign rdata     = c_q.rdata;
  assign rresp     = c_q.rresp;
  assign cpu_stall = (c_q.stall_cnt != 3'h0);
  assign ready_irq = c_q.rie && !busy; // [R20]

  // read data mux; read strobe never stored so reads as zero
  always_comb begin
    unique case (araddr)
      eeprom_pkg::CTRL_OFS: rd_val = ctrl_rd; // [R22]
      eeprom_pkg::ADDR_OFS: rd_val = {20'h00000, c_q.addr};
      eeprom_pkg::DATA_OFS: rd_val = {24'h000000, c_q.data};
      default:              rd_val = 32'h00000000;
    endcase
  end

  // bus side next state
  always_comb begin
    c_d        = c_q;
    start_pg   = 1'b0;
    rd_req     = 1'b0;
    rd_go      = 1'b0;
    mode_wr    = 1'b0;
    mode_wdata = c_q.wdata[eeprom_pkg::MODE_LSB +: 2];
    if (awvalid && awready) begin
      c_d.aw_have = 1'b1;
      c_d.waddr   = awaddr;
    end
    if (wvalid && wready) begin
      c_d.w_have = 1'b1;
      c_d.wdata  = wdata;
      c_d.wstrb  = wstrb;
    end
    // arm window counts down, then expires
    if (c_q.arm) begin
      if (c_q.arm_cnt == 3'h0)
        c_d.arm = 1'b0; // [R19] [R8]
      else
        c_d.arm_cnt = c_q.arm_cnt - 3'h1;
    end
    if (c_q.stall_cnt != 3'h0)
      c_d.stall_cnt = c_q.stall_cnt - 3'h1;
    if (c_q.bvalid && bready)
      c_d.bvalid = 1'b0;
    // register write once both address and data are held
    if (c_q.aw_have && c_q.w_have && !c_q.bvalid) begin
      c_d.aw_have = 1'b0;
      c_d.w_have  = 1'b0;
      c_d.bvalid  = 1'b1;
      c_d.bresp   = eeprom_pkg::RESP_OKAY;
      unique case (c_q.waddr)
        eeprom_pkg::CTRL_OFS: begin
          if (c_q.wstrb[0]) begin
            c_d.rie = c_q.wdata[eeprom_pkg::RIE_BIT];
            mode_wr = 1'b1;
            // strobe only counts inside a live arm window
            if (c_q.wdata[eeprom_pkg::PG_BIT]) begin
              if (c_q.arm && !busy && !flash_self_program_enable &&
                  e_q.mode != eeprom_pkg::M_RSVD) begin // [R2] [R6] [R1]
                start_pg      = 1'b1;
                c_d.arm       = 1'b0;
                c_d.stall_cnt = eeprom_pkg::STALL_PROG; // [R11]
              end
            end else if (c_q.wdata[eeprom_pkg::ARM_BIT] && !c_q.arm) begin
              c_d.arm     = 1'b1; // [R3]
              c_d.arm_cnt = eeprom_pkg::ARM_CYC - 3'h1;
            end
            if (c_q.wdata[eeprom_pkg::RD_BIT]) begin
              rd_req = 1'b1;
              // a program start in the same write wins; the read is dropped
              if (!busy && !start_pg) begin // [R15]
                rd_go         = 1'b1;
                c_d.data      = mem_rd; // [R13]
                c_d.stall_cnt = eeprom_pkg::STALL_READ; // [R14]
              end
            end
          end
        end
        eeprom_pkg::ADDR_OFS: begin
          if (!busy) begin // [R15]
            if (c_q.wstrb[0])
              c_d.addr[7:0] = c_q.wdata[7:0];
            if (c_q.wstrb[1])
              c_d.addr[11:8] = c_q.wdata[11:8];
          end
        end
        eeprom_pkg::DATA_OFS: begin
          if (c_q.wstrb[0])
            c_d.data = c_q.wdata[7:0];
        end
        default: c_d.bresp = eeprom_pkg::RESP_SLV;
      endcase
    end
    // read channel; arready low while rvalid so no clash
    if (c_q.rvalid && rready)
      c_d.rvalid = 1'b0;
    if (arvalid && arready) begin
      c_d.rvalid = 1'b1;
      c_d.rdata  = rd_val;
      c_d.rresp  = (araddr == eeprom_pkg::CTRL_OFS ||
                    araddr == eeprom_pkg::ADDR_OFS ||
                    araddr == eeprom_pkg::DATA_OFS) ?
                   eeprom_pkg::RESP_OKAY : eeprom_pkg::RESP_SLV;
    end
  end

  // bus side registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      c_q <= '0;
    else
      c_q <= c_d;
  end

  // engine next state; counts synchronised oscillator edges
  always_comb begin
    e_d        = e_q;
    e_d.osc_s1 = osc_clk;
    e_d.osc_s2 = e_q.osc_s1;
    e_d.osc_s3 = e_q.osc_s2;
    // mode held while busy; system reset clears it only when idle
    if (!busy) begin
      if (sys_rst)
        e_d.mode = eeprom_pkg::prog_mode_t'(eeprom_pkg::MODE_RESET);
      else if (mode_wr)
        e_d.mode = eeprom_pkg::prog_mode_t'(mode_wdata); // [R21]
    end
    unique case (e_q.st)
      eeprom_pkg::ENG_IDLE: begin
        if (start_pg) begin
          e_d.st       = eeprom_pkg::ENG_BUSY;
          e_d.cap_mode = e_q.mode; // [R23]
          e_d.cap_addr = c_q.addr;
          e_d.cap_data = c_q.data;
          e_d.cnt      = (e_q.mode == eeprom_pkg::M_ATOMIC) ?
                         15'(OSC_ATOMIC - 1) : 15'(OSC_SPLIT - 1); // [R12]
        end
      end
      eeprom_pkg::ENG_BUSY: begin
        if (done)
          e_d.st = eeprom_pkg::ENG_IDLE; // [R10]
        else if (osc_tick)
          e_d.cnt = e_q.cnt - 15'h0001;
      end
      default: e_d.st = eeprom_pkg::ENG_IDLE;
    endcase
  end

  // engine registers; sys_rst clears only the mode, and only when idle, so a write finishes
  always_ff @(posedge clk or posedge por_rst) begin
    if (por_rst) begin
      e_q     <= '0;
      e_q.st  <= eeprom_pkg::ENG_IDLE;
    end else begin
      e_q <= e_d; // [R17]
    end
  end

  // array update at the end of the programming time
  always_ff @(posedge clk) begin
    if (done) begin
      unique case (e_q.cap_mode) // [R18]
        eeprom_pkg::M_ERASE: mem[e_q.cap_addr[AW-1:0]] <= 8'hFF;
        eeprom_pkg::M_WRITE:
          mem[e_q.cap_addr[AW-1:0]] <= mem[e_q.cap_addr[AW-1:0]] &
                                       e_q.cap_data;
        default: mem[e_q.cap_addr[AW-1:0]] <= e_q.cap_data;
      endcase
    end
  end

  // checks gated by both resets; a write spanning sys_rst is judged again once sys_rst drops
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || por_rst);

  sequence stall_two;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence
  sequence stall_four;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  arm_gate_a: assert property (start_pg |-> c_q.arm) // [R2]
    else $error("program start without arm");
  flash_block_a: assert property ( // [R6]
      start_pg |-> !flash_self_program_enable)
    else $error("program start during flash self-program");
  arm_expire_a: assert property ($rose(c_q.arm) |-> ##4 !c_q.arm) // [R19]
    else $error("arm bit outlived its window");
  strobe_clear_a: assert property ( // [R10]
      done |=> !busy && ctrl_rd[1] == 1'b0)
    else $error("strobe did not clear at end");
  // the strobe may only drop once the counted time is over
  strobe_drop_a: assert property ($fell(busy) |-> $past(done)) // [R10]
    else $error("strobe cleared without elapsed time");
  busy_hold_a: assert property (busy && !done |=> busy) // [R10]
    else $error("strobe cleared before time elapsed");
  prog_stall_a: assert property (start_pg |=> stall_two) // [R11]
    else $error("program stall length wrong");
  read_stall_a: assert property (rd_go |=> stall_four) // [R14]
    else $error("read stall length wrong");
  read_refused_a: assert property (rd_req && busy |-> !rd_go) // [R15]
    else $error("read accepted while busy");
  addr_lock_a: assert property (busy |=> $stable(c_q.addr)) // [R15]
    else $error("address changed while busy");
  mode_lock_a: assert property (busy |=> $stable(e_q.mode)) // [R21]
    else $error("mode changed while busy");
  ready_rise_a: assert property ( // [R20]
      $fell(busy) && c_q.rie |-> ready_irq)
    else $error("ready level missing after write");
  capture_hold_a: assert property (busy && $past(busy) |-> // [R23]
      $stable(e_q.cap_addr) && $stable(e_q.cap_data))
    else $error("captured operands moved");
  read_data_a: assert property (rd_go |=> c_q.data == $past(mem_rd)) // [R13]
    else $error("read data not loaded");
  start_load_a: assert property ( // [R1] [R23]
      start_pg |=> busy && e_q.cap_addr == $past(c_q.addr))
    else $error("program start did not capture address");
  start_mode_a: assert property ( // [R18]
      start_pg |-> !busy && e_q.mode != eeprom_pkg::M_RSVD)
    else $error("program start in reserved mode or while busy");
  stall_cause_a: assert property ( // [R11] [R14]
      $rose(cpu_stall) |-> $past(start_pg) || $past(rd_go))
    else $error("processor stalled with no strobe");
endmodule // eeprom_access

/* File: dv/eeprom_access_control_test.sv */
// Purpose: self-checking bench for the data EEPROM access block
// Assumes: AXI4-Lite register port, programming counts shortened
// Notes:   bready and rready stay high, so the bus answer is never stalled
`timescale 1ns/1ps
module eeprom_access_control_test;
  localparam int NA = 8;
  localparam int NS = 4;
  logic        clk = 0, sys_rst = 1, por_rst = 1, osc_clk = 0;
  logic        flash_self_program_enable = 0;
  logic [3:0]  awaddr = '0, araddr = '0, wstrb = 4'hF;
  logic        awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic [31:0] wdata = '0, rdata, rd;
  logic        awready, wready, bvalid, arready, rvalid, cpu_stall, ready_irq;
  logic [1:0]  bresp, rresp;
  logic [11:0] a;
  logic [7:0]  d, o;
  int          bad_count = 0, cmp_count = 0, stall_n = 0, osc_n = 0;
  int          seed = 32'hB4FF3F10;

  eeprom_access #(.OSC_ATOMIC(NA), .OSC_SPLIT(NS)) DUT (
    .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .osc_clk(osc_clk),
    .flash_self_program_enable(flash_self_program_enable),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cpu_stall(cpu_stall), .ready_irq(ready_irq));

  // free-running oscillator; even half period keeps edges off clk rises
  always #5 clk = ~clk;
  always #32 osc_clk = ~osc_clk;
  // stall cycles and busy-time oscillator edges (busy shows as irq low)
  always @(posedge clk) if (cpu_stall === 1'b1) stall_n++;
  always @(posedge osc_clk) if (ready_irq === 1'b0) osc_n++;

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task axi_wr(input logic [3:0] ad, input logic [31:0] dt,
              input logic [1:0] er);
    int n;
    awaddr <= ad; wdata <= dt; awvalid <= 1; wvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid === 1'b1) break;
    end
    if (n == 50) begin bad_count++; report_and_stop; end
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask

  task axi_rd(input logic [3:0] ad, input logic [1:0] er);
    int n;
    araddr <= ad; arvalid <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid === 1'b1) break;
    end
    if (n == 50) begin bad_count++; report_and_stop; end
    rd = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask

  // expected array byte after one operation in mode m
  function automatic logic [7:0] nv_expect(logic [1:0] m, logic [7:0] ov,
                                           logic [7:0] nv);
    case (m)
      2'h0: return nv;
      2'h1: return 8'hFF;
      2'h2: return ov & nv;
      default: return ov;
    endcase
  endfunction

  task wr(input logic [3:0] ad, input logic [31:0] dt);
    axi_wr(ad, dt, eeprom_pkg::RESP_OKAY);
  endtask

  // arm then strobe back to back; the strobe lands one cycle before the window closes
  task prog(input logic [11:0] pa, input logic [7:0] pd, input logic [1:0] m);
    wr(eeprom_pkg::ADDR_OFS, {20'h0, pa});
    wr(eeprom_pkg::DATA_OFS, {24'h0, pd});
    wr(eeprom_pkg::CTRL_OFS, {26'h0, m, 4'hC});
    stall_n = 0;
    osc_n = 0;
    wr(eeprom_pkg::CTRL_OFS, {26'h0, m, 4'hA});
  endtask

  task wait_idle;
    int n;
    for (n = 0; n < 500; n++) begin
      axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
      if (rd[eeprom_pkg::PG_BIT] === 1'b0) break;
    end
    if (n == 500) begin bad_count++; report_and_stop; end
  endtask

  task rd_byte(input logic [11:0] ra, input logic [7:0] e);
    wr(eeprom_pkg::ADDR_OFS, {20'h0, ra});
    stall_n = 0;
    wr(eeprom_pkg::CTRL_OFS, 32'h09);
    repeat (6) @(posedge clk);
    chk("read stall", 32'h4, stall_n);
    axi_rd(eeprom_pkg::DATA_OFS, eeprom_pkg::RESP_OKAY);
    chk("data", {24'h0, e}, rd);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("read bit", 32'h0, {31'h0, rd[eeprom_pkg::RD_BIT]});
  endtask

  initial begin
    #900000 bad_count++;
    report_and_stop;
  end

  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 0;
    por_rst <= 0;
    @(posedge clk);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("ctrl reset", 32'h0, rd);
    axi_rd(4'hC, eeprom_pkg::RESP_SLV);
    chk("unmapped read", 32'h0, rd);
    axi_wr(4'hC, 32'h1, eeprom_pkg::RESP_SLV);
    // every mode on a byte first set by an atomic write
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      o = $random(seed);
      d = (i == 0) ? 8'h00 : $random(seed);
      prog(a, o, 2'h0);
      wait_idle;
      prog(a, d, i[1:0]);
      wait_idle;
      chk("prog stall", (i % 4 == 3) ? 0 : 2, stall_n);
      chk("osc time", 1, (i % 4 == 3) ? osc_n == 0 :
          osc_n >= ((i % 4 == 0) ? NA : NS) - 1 &&
          osc_n <= ((i % 4 == 0) ? NA : NS) + 3);
      rd_byte(a, nv_expect(i[1:0], o, d));
    end
    // strobe without arming, late strobe, flash busy
    wr(eeprom_pkg::CTRL_OFS, 32'h0A);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("no arm", 32'h08, rd);
    wr(eeprom_pkg::CTRL_OFS, 32'h0C);
    repeat (8) @(posedge clk);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("arm expiry", 32'h08, rd);
    wr(eeprom_pkg::CTRL_OFS, 32'h0A);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("late strobe", 32'h08, rd);
    flash_self_program_enable <= 1;
    wr(eeprom_pkg::CTRL_OFS, 32'h0C);
    wr(eeprom_pkg::CTRL_OFS, 32'h0A);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("flash lock", 32'h08, rd);
    flash_self_program_enable <= 0;
    // lockouts while busy
    prog(a, 8'h5A, 2'h0);
    chk("irq busy", 0, ready_irq);
    wr(eeprom_pkg::ADDR_OFS, {20'h0, ~a});
    wr(eeprom_pkg::CTRL_OFS, 32'h39);
    axi_rd(eeprom_pkg::ADDR_OFS, eeprom_pkg::RESP_OKAY);
    chk("addr hold", {20'h0, a}, rd);
    axi_rd(eeprom_pkg::CTRL_OFS, eeprom_pkg::RESP_OKAY);
    chk("mode hold", 32'h0A, rd);
    wait_idle;
    chk("irq idle", 1, ready_irq);
    axi_rd(eeprom_pkg::DATA_OFS, eeprom_pkg::RESP_OKAY);
    chk("no read", 32'h5A, rd);
    rd_byte(a, 8'h5A);
    // system reset in mid-write
    prog(a, 8'hC3, 2'h0);
    sys_rst <= 1;
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    wait_idle;
    rd_byte(a, 8'hC3);
    // program and read in one write: the program start wins the stall
    wr(eeprom_pkg::CTRL_OFS, 32'h0C);
    stall_n = 0;
    wr(eeprom_pkg::CTRL_OFS, 32'h0B);
    repeat (4) @(posedge clk);
    chk("joint stall", 2, stall_n);
    wait_idle;
    report_and_stop;
  end
endmodule // eeprom_access_control_test

/* File: pkg/eeprom_pkg.sv */
// Purpose: shared constants and types for the data EEPROM access block
// Assumes: AXI4-Lite register access, one system clock
// Notes:   control bit positions follow the control register layout
package eeprom_pkg;
  // register byte offsets
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] ADDR_OFS = 4'h4;
  localparam logic [3:0] DATA_OFS = 4'h8;
  // control register bit positions
  localparam int RD_BIT   = 0;
  localparam int PG_BIT   = 1;
  localparam int ARM_BIT  = 2;
  localparam int RIE_BIT  = 3;
  localparam int MODE_LSB = 4;
  // cycle counts
  localparam logic [2:0] ARM_CYC    = 3'h4;
  localparam logic [2:0] STALL_PROG = 3'h2;
  localparam logic [2:0] STALL_READ = 3'h4;
  // programming times in oscillator cycles
  localparam int OSC_ATOMIC = 26368;
  localparam int OSC_SPLIT  = 13960;
  // reset values and bus answers
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;

  typedef enum logic [1:0] {
    M_ATOMIC = 2'h0, M_ERASE = 2'h1, M_WRITE = 2'h2, M_RSVD = 2'h3
  } prog_mode_t;

  typedef enum logic [1:0] {ENG_IDLE = 2'b01, ENG_BUSY = 2'b10} eng_state_t;

  // bus-side state, cleared by system reset
  typedef struct packed {
    logic        aw_have;
    logic [3:0]  waddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        arm;
    logic [2:0]  arm_cnt;
    logic        rie;
    logic [11:0] addr;
    logic [7:0]  data;
    logic [2:0]  stall_cnt;
  } core_t;

  // programming engine state; system reset clears only the mode, and only when idle
  typedef struct packed {
    eng_state_t  st;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic [14:0] cnt;
    prog_mode_t  mode;
    prog_mode_t  cap_mode;
    logic [11:0] cap_addr;
    logic [7:0]  cap_data;
  } eng_t;
endpackage
